// [include/bfps_pkg.sv]
// Purpose: shared constants for the backlight fault and power sequencer
// Assumes: 125 MHz core clock
// Notes: fault_status_channel_enable and 02h field layout, timing counts
package bfps_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_MHZ = 125; // core clock rate
	localparam int SOFT_STEP_US = 1000; // 7 steps over 7 ms
	localparam int SOFT_STEP_CYC = SOFT_STEP_US * CLK_MHZ; // cycles per step
	localparam int SHORT_TMO_US = 3000; // short time-out
	localparam int SHORT_TMO_CYC = SHORT_TMO_US * CLK_MHZ; // cycles for short time-out
	localparam int OPEN_TMO_US = 2000; // open time-out, own default
	localparam int OPEN_TMO_CYC = OPEN_TMO_US * CLK_MHZ;
	localparam int OVERCUR_TMO_US = 100; // overcurrent report time-out, own default
	localparam int OVERCUR_TMO_CYC = OVERCUR_TMO_US * CLK_MHZ; // cycles before reporting
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_CFG = 8'h02; // configuration register
	localparam logic [7:0] ADDR_STAT = 8'h10; // fault status and channel enable
	localparam int CFG_SHORT_EN_BIT = 4; // short guard enable
	localparam logic [7:0] CFG_RESET = 8'h10; // short guard on by default
	localparam int ST_CH1_EN_BIT = 1; // channel 1 enable
	localparam int ST_CH2_EN_BIT = 2; // channel 2 enable
	localparam int ST_OVERCUR_BIT = 4; // overcurrent flag
	localparam int ST_STRING_BIT = 6; // open or short flag
	localparam int ST_OTP_BIT = 7; // over-temperature flag
	localparam logic [7:0] STAT_RESET = 8'h06; // both channels enabled
	// ****************************************
	// soft start
	// ****************************************
	localparam logic [2:0] ILIM_FIRST = 3'h0; // code 0 = 125 mA
	localparam logic [2:0] ILIM_LAST = 3'h7; // code 7 = 1 A
	// sequencer states
	typedef enum logic [2:0] {
		ST_OFF = 3'b000, // shutdown
		ST_PRECHG = 3'b001, // low current boost, sinks off
		ST_SOFT = 3'b010, // stepping the current limit
		ST_RUN = 3'b011, // normal regulation
		ST_OTP = 3'b100 // latched thermal shutdown
	} bfps_state_t;
endpackage

// [src/bfps_core.sv]
// Purpose: power sequencing, soft start and fault handling of a two-channel backlight
// Assumes: comparator inputs are asynchronous and pass two flip-flops; register
//          port is a plain byte read/write port from the serial decoder
// Notes: analog loops and dimming decoding live elsewhere
module bfps_core #(
	parameter int SOFT_STEP = bfps_pkg::SOFT_STEP_CYC, // cycles per soft step
	parameter int SHORT_TMO = bfps_pkg::SHORT_TMO_CYC, // short time-out cycles
	parameter int OPEN_TMO = bfps_pkg::OPEN_TMO_CYC, // open time-out cycles
	parameter int OVERCUR_TMO = bfps_pkg::OVERCUR_TMO_CYC // overcurrent report cycles
) (
	input wire logic clk,
	input wire logic reset, // secondary lockout of main supply
	input wire logic main_supply_ok, // main supply above lockout
	input wire logic io_supply_ok, // io supply above lockout
	input wire logic enable_pin,
	input wire logic brightness_nonzero, // from dimming decoder, same clock
	input wire logic over_temp, // thermal comparator
	input wire logic boost_overcurrent_guard, // switch current at limit
	input wire logic boost_output_above_start, // output above 6.8V
	input wire logic boost_output_at_max, // output at 25V
	input wire logic [1:0] led_channel_sink_low, // channel current below target
	input wire logic [1:0] led_channel_sink_at_max, // good channel headroom at 5.5V
	input wire logic [1:0] led_channel_sink_short, // headroom above 4.5V
	input wire logic limit_sufficient, // current limit regulates target
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic boost_switch_en, // boost may switch
	output logic boost_low_current, // precharge mode
	output logic boost_cycle_kill, // end current switching cycle
	output logic boost_raise_output, // push output up during open time-out
	output logic [2:0] boost_current_limit, // code n = 125mA*(n+1)
	output logic [1:0] led_channel_sink_en,
	output logic overvoltage_monitor_en // channel overvoltage monitor
);
	// ****************************************
	// input synchronisers
	// ****************************************
	localparam int NSYNC = 14; // number of async inputs
	logic [NSYNC-1:0] sync1_r; // first stage, read only by second
	logic [NSYNC-1:0] sync2_r; // second stage
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {main_supply_ok, io_supply_ok, enable_pin, over_temp,
				boost_overcurrent_guard, boost_output_above_start, boost_output_at_max,
				led_channel_sink_low, led_channel_sink_at_max, led_channel_sink_short,
				limit_sufficient};
			sync2_r <= sync1_r;
		end
	end
	logic main_ok, io_ok, en_ok, otp_s, overcur_s, out_above_start, out_at_max, lim_ok;
	logic [1:0] ch_low, ch_max, ch_short;
	assign {main_ok, io_ok, en_ok, otp_s, overcur_s, out_above_start, out_at_max,
		ch_low, ch_max, ch_short, lim_ok} = sync2_r;

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] cfg_r; // config register 02h
	logic [7:0] stat_r; // status and channel enable 10h
	logic overcur_set, str_set, otp_set; // status set events
	logic [1:0] ch_clr; // channel enable clear events
	// register contents held through lockouts; only reset clears them
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_r <= bfps_pkg::CFG_RESET;
		end else if (reg_wr && reg_addr == bfps_pkg::ADDR_CFG) begin
			cfg_r <= reg_wdata;
		end
	end
	logic [7:0] stat_nxt; // next status value
	// status next value: hardware set and clear win over a software write
	always_comb begin
		stat_nxt = stat_r;
		if (reg_wr && reg_addr == bfps_pkg::ADDR_STAT) begin
			stat_nxt = reg_wdata;
		end
		if (overcur_set) begin
			stat_nxt[bfps_pkg::ST_OVERCUR_BIT] = 1'b1;
		end
		if (str_set) begin
			stat_nxt[bfps_pkg::ST_STRING_BIT] = 1'b1;
		end
		if (otp_set) begin
			stat_nxt[bfps_pkg::ST_OTP_BIT] = 1'b1;
		end
		if (ch_clr[0]) begin
			stat_nxt[bfps_pkg::ST_CH1_EN_BIT] = 1'b0;
		end
		if (ch_clr[1]) begin
			stat_nxt[bfps_pkg::ST_CH2_EN_BIT] = 1'b0;
		end
	end
	// status register, kept through lockouts
	always_ff @(posedge clk) begin
		if (reset) begin
			stat_r <= bfps_pkg::STAT_RESET;
		end else begin
			stat_r <= stat_nxt;
		end
	end
	// read mux
	always_comb begin
		if (reg_addr == bfps_pkg::ADDR_CFG) begin
			reg_rdata = cfg_r;
		end else if (reg_addr == bfps_pkg::ADDR_STAT) begin
			reg_rdata = stat_r;
		end else begin
			reg_rdata = 8'h00;
		end
	end
	logic short_en;
	assign short_en = cfg_r[bfps_pkg::CFG_SHORT_EN_BIT];
	logic [1:0] ch_en_bits;
	assign ch_en_bits = {stat_r[bfps_pkg::ST_CH2_EN_BIT], stat_r[bfps_pkg::ST_CH1_EN_BIT]};

	// ****************************************
	// sequencer
	// ****************************************
	bfps_pkg::bfps_state_t state_r;
	logic start_ok; // all four start conditions, any order
	assign start_ok = main_ok && io_ok && en_ok && brightness_nonzero;
	logic cyc_lost; // main supply or enable low, unlatches thermal
	assign cyc_lost = !main_ok || !en_ok;
	logic [31:0] step_cnt_r; // soft step timer
	logic step_done;
	assign step_done = step_cnt_r >= 32'(SOFT_STEP - 1);
	logic [2:0] ilim_r;
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= bfps_pkg::ST_OFF;
		end else if (otp_s && state_r != bfps_pkg::ST_OTP) begin
			state_r <= bfps_pkg::ST_OTP;
		end else begin
			case (state_r)
				bfps_pkg::ST_OFF: begin
					if (start_ok) begin
						state_r <= bfps_pkg::ST_PRECHG;
					end
				end
				bfps_pkg::ST_PRECHG: begin
					if (!start_ok) begin
						state_r <= bfps_pkg::ST_OFF;
					end else if (out_above_start) begin
						state_r <= bfps_pkg::ST_SOFT;
					end
				end
				bfps_pkg::ST_SOFT: begin
					if (!start_ok) begin
						state_r <= bfps_pkg::ST_OFF;
					end else if (lim_ok || (ilim_r == bfps_pkg::ILIM_LAST && step_done)) begin
						state_r <= bfps_pkg::ST_RUN;
					end
				end
				bfps_pkg::ST_RUN: begin
					if (!start_ok) begin
						state_r <= bfps_pkg::ST_OFF;
					end
				end
				bfps_pkg::ST_OTP: begin
					if (cyc_lost) begin
						state_r <= bfps_pkg::ST_OFF;
					end
				end
				default: begin
					state_r <= bfps_pkg::ST_OFF;
				end
			endcase
		end
	end
	assign otp_set = otp_s && state_r != bfps_pkg::ST_OTP;

	// soft start limit stepping, one code per millisecond
	always_ff @(posedge clk) begin
		if (reset || state_r != bfps_pkg::ST_SOFT) begin
			step_cnt_r <= '0;
			if (reset || state_r != bfps_pkg::ST_RUN) begin
				ilim_r <= bfps_pkg::ILIM_FIRST;
			end
		end else if (step_done) begin
			step_cnt_r <= '0;
			if (ilim_r != bfps_pkg::ILIM_LAST) begin
				ilim_r <= ilim_r + 3'h1;
			end
		end else begin
			step_cnt_r <= step_cnt_r + 32'h1;
		end
	end

	// ****************************************
	// fault timers
	// ****************************************
	logic lit; // sinks may be on
	assign lit = state_r == bfps_pkg::ST_SOFT || state_r == bfps_pkg::ST_RUN;
	logic [31:0] overcur_cnt_r; // overcurrent persistence timer
	// overcurrent must persist in the run state to be reported
	always_ff @(posedge clk) begin
		if (reset || !overcur_s || state_r != bfps_pkg::ST_RUN) begin
			overcur_cnt_r <= '0;
		end else if (overcur_cnt_r != 32'(OVERCUR_TMO)) begin
			overcur_cnt_r <= overcur_cnt_r + 32'h1;
		end
	end
	assign overcur_set = overcur_cnt_r == 32'(OVERCUR_TMO - 1);

	logic [31:0] open_cnt_r [2]; // per-channel open timer
	logic [31:0] short_cnt_r [2]; // per-channel short timer
	logic [1:0] open_hit, short_hit;
	for (genvar i = 0; i < 2; i++) begin : g_ch
		always_ff @(posedge clk) begin
			if (reset || !lit || !ch_en_bits[i] || !ch_low[i]) begin
				open_cnt_r[i] <= '0;
			end else if (open_cnt_r[i] != 32'(OPEN_TMO)) begin
				open_cnt_r[i] <= open_cnt_r[i] + 32'h1;
			end
		end
		always_ff @(posedge clk) begin
			if (reset || !lit || !short_en || !ch_en_bits[i] || !ch_short[i]) begin
				short_cnt_r[i] <= '0;
			end else if (short_cnt_r[i] != 32'(SHORT_TMO)) begin
				short_cnt_r[i] <= short_cnt_r[i] + 32'h1;
			end
		end
		assign open_hit[i] = open_cnt_r[i] == 32'(OPEN_TMO - 1);
		assign short_hit[i] = short_cnt_r[i] == 32'(SHORT_TMO - 1);
	end
	// open clears its own channel, short clears the normal one
	assign ch_clr = open_hit | {short_hit[0], short_hit[1]};
	assign str_set = |open_hit || |short_hit;

	// ****************************************
	// outputs
	// ****************************************
	logic [1:0] open_pend; // open timer running
	assign open_pend = {open_cnt_r[1] != 32'h0, open_cnt_r[0] != 32'h0};
	always_ff @(posedge clk) begin
		if (reset) begin
			boost_switch_en <= 1'b0;
			boost_low_current <= 1'b0;
			boost_cycle_kill <= 1'b0;
			boost_raise_output <= 1'b0;
			boost_current_limit <= bfps_pkg::ILIM_FIRST;
			led_channel_sink_en <= 2'b00;
			overvoltage_monitor_en <= 1'b0;
		end else begin
			boost_switch_en <= state_r != bfps_pkg::ST_OFF && state_r != bfps_pkg::ST_OTP
				&& !otp_s && io_ok && main_ok;
			boost_low_current <= state_r == bfps_pkg::ST_PRECHG;
			boost_cycle_kill <= overcur_s;
			// climb until 25V or good channel at 5.5V
			boost_raise_output <= |open_pend && !out_at_max && !(|(ch_max & ~ch_low));
			boost_current_limit <= ilim_r;
			led_channel_sink_en <= (lit && !otp_s && io_ok) ? (ch_en_bits & ~ch_clr) : 2'b00;
			overvoltage_monitor_en <= !short_en;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_otp_off;
		@(posedge clk) disable iff (reset) otp_s |=> !boost_switch_en && led_channel_sink_en == 2'b00;
	endproperty
	a_otp_off: assert property (p_otp_off) else $error("thermal did not stop");
	property p_otp_flag;
		@(posedge clk) disable iff (reset) otp_set |=> stat_r[bfps_pkg::ST_OTP_BIT];
	endproperty
	a_otp_flag: assert property (p_otp_flag) else $error("thermal flag missing");
	property p_io_off;
		@(posedge clk) disable iff (reset) !io_ok |=> !boost_switch_en && led_channel_sink_en == 2'b00;
	endproperty
	a_io_off: assert property (p_io_off) else $error("io lockout ignored");
	property p_start;
		@(posedge clk) disable iff (reset) (state_r == bfps_pkg::ST_OFF && !start_ok) |=> state_r != bfps_pkg::ST_PRECHG;
	endproperty
	a_start: assert property (p_start) else $error("started without all conditions");
	property p_lost;
		@(posedge clk) disable iff (reset) (lit && !start_ok && !otp_s) |=> state_r == bfps_pkg::ST_OFF;
	endproperty
	a_lost: assert property (p_lost) else $error("no power off");
	property p_pre;
		@(posedge clk) disable iff (reset) state_r == bfps_pkg::ST_PRECHG |=> led_channel_sink_en == 2'b00;
	endproperty
	a_pre: assert property (p_pre) else $error("sinks on in precharge");
	property p_step;
		@(posedge clk) disable iff (reset) (state_r == bfps_pkg::ST_SOFT && step_done && ilim_r != bfps_pkg::ILIM_LAST) |=> ilim_r == $past(ilim_r) + 3'h1;
	endproperty
	a_step: assert property (p_step) else $error("soft step missed");
	property p_overcur_soft;
		@(posedge clk) disable iff (reset) state_r == bfps_pkg::ST_SOFT |-> !overcur_set;
	endproperty
	a_overcur_soft: assert property (p_overcur_soft) else $error("overcurrent in soft start");
	property p_ovm;
		@(posedge clk) disable iff (reset) !short_en |=> overvoltage_monitor_en && short_cnt_r[0] == 32'h0;
	endproperty
	a_ovm: assert property (p_ovm) else $error("monitor swap wrong");
	c_run: cover property (@(posedge clk) state_r == bfps_pkg::ST_RUN);
	c_otp: cover property (@(posedge clk) state_r == bfps_pkg::ST_OTP);
	c_str: cover property (@(posedge clk) str_set);
endmodule

// [verification/bfps_plant_model.sv]
// Purpose: far side of the sequencer: boost output and limit feedback
// Assumes: output builds only while the boost switches
// Notes: behavioural; the testbench drives the host pins itself
module bfps_plant_model (
	input wire logic clk,
	input wire logic boost_switch_en,
	input wire logic boost_raise_output,
	input wire logic [2:0] boost_current_limit,
	input wire logic [2:0] lim_need, // code that regulates the target
	output logic boost_output_above_start,
	output logic boost_output_at_max,
	output logic limit_sufficient
);
	timeunit 1ns;
	timeprecision 1ps;
	int charge = 0; // crude output voltage
	// ****************************************
	// output build-up
	// ****************************************
	// charge while switching, collapse when stopped
	always @(posedge clk) begin
		if (!boost_switch_en)
			charge <= 0;
		else if (charge < 40)
			charge <= charge + 1;
	end
	assign boost_output_above_start = charge >= 6; // start level passed
	assign boost_output_at_max = boost_raise_output && charge >= 10; // ceiling
	assign limit_sufficient = boost_current_limit >= lim_need; // regulates
endmodule

// [verification/test_bfps_core.sv]
// Purpose: self-checking bench for the sequencer core
// Assumes: short time-outs set by parameter
// Notes: inputs change at the falling edge
module test_bfps_core;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SS = 20; // cycles per soft step
	localparam int STO = 30; // short time-out
	localparam int OTO = 25; // open time-out
	localparam int CTO = 15; // overcurrent report time-out
	logic clk = 0;
	logic reset = 1;
	logic [3:0] cond = 4'h0; // main, io, enable, brightness
	logic over_temp = 0;
	logic overcur = 1'b0; // switch current at limit
	logic [1:0] sink_at_max = 2'h0; // good channel headroom at ceiling
	logic [1:0] sink_low = 0;
	logic [1:0] sink_short = 0;
	logic reg_wr = 0;
	logic [7:0] reg_addr = bfps_pkg::ADDR_STAT; // idle on status
	logic [7:0] reg_wdata = 0;
	logic [2:0] lim_need = 3'h7;
	logic [7:0] reg_rdata;
	logic boost_switch_en, boost_low_current, boost_cycle_kill, boost_raise_output;
	logic [2:0] boost_current_limit;
	logic [1:0] led_channel_sink_en;
	logic overvoltage_monitor_en, above_start, at_max, lim_ok;
	int miscompares = 0;
	int checked = 0;
	always #4 clk = ~clk;
	// ****************************************
	// instances
	// ****************************************
	bfps_core #(.SOFT_STEP(SS), .SHORT_TMO(STO), .OPEN_TMO(OTO),
		.OVERCUR_TMO(CTO)) bfps_core_i (
		.clk(clk), .reset(reset), .main_supply_ok(cond[0]), .io_supply_ok(cond[1]),
		.enable_pin(cond[2]), .brightness_nonzero(cond[3]), .over_temp(over_temp),
		.boost_overcurrent_guard(overcur), .boost_output_above_start(above_start),
		.boost_output_at_max(at_max), .led_channel_sink_low(sink_low),
		.led_channel_sink_at_max(sink_at_max), .led_channel_sink_short(sink_short),
		.limit_sufficient(lim_ok), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .boost_switch_en(boost_switch_en),
		.boost_low_current(boost_low_current), .boost_cycle_kill(boost_cycle_kill),
		.boost_raise_output(boost_raise_output), .boost_current_limit(boost_current_limit),
		.led_channel_sink_en(led_channel_sink_en),
		.overvoltage_monitor_en(overvoltage_monitor_en));
	bfps_plant_model bfps_plant_model_i (.clk(clk), .boost_switch_en(boost_switch_en),
		.boost_raise_output(boost_raise_output), .boost_current_limit(boost_current_limit),
		.lim_need(lim_need), .boost_output_above_start(above_start),
		.boost_output_at_max(at_max), .limit_sufficient(lim_ok));
	// ****************************************
	// tasks
	// ****************************************
	// closing verdict
	task automatic stop_test();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// byte compare
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// observed outputs by index
	function automatic logic [7:0] obs(input int w);
		case (w)
			0: return reg_rdata;
			1: return {6'h0, led_channel_sink_en};
			2: return {6'h0, boost_low_current, boost_switch_en};
			3: return {5'h0, boost_current_limit};
			4: return {7'h0, boost_raise_output};
			default: return {7'h0, boost_cycle_kill};
		endcase
	endfunction
	// bounded wait for masked value, then compare
	task automatic poll(input int w, input logic [7:0] m, input logic [7:0] e, input int lim);
		int n;
		n = 0;
		while ((obs(w) & m) !== e && n < lim) begin
			@(negedge clk);
			n++;
		end
		cmp(obs(w) & m, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = bfps_pkg::ADDR_STAT;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		cmp(reg_rdata, e);
		reg_addr = bfps_pkg::ADDR_STAT;
	endtask
	task automatic rst();
		reset = 1'b1;
		cond = 4'h0;
		sink_low = 2'h0;
		sink_short = 2'h0;
		sink_at_max = 2'h0;
		repeat (3) @(negedge clk);
		reset = 1'b0;
	endtask
	// full power-up; checks precharge, first limit, step timing, early stop
	task automatic start_up(input logic [2:0] need);
		int n;
		lim_need = need;
		cond = 4'hF; // main, io, enable and brightness all up
		poll(2, 8'h03, 8'h03, 12);
		cmp(obs(1), 8'h00);
		poll(1, 8'h03, 8'h03, 30);
		cmp(obs(3), 8'h00);
		n = 0;
		while (boost_current_limit !== need && n < 10 * SS) begin
			@(negedge clk);
			n++;
		end
		cmp({7'h0, n >= (need - 1) * SS && n <= (need + 1) * SS}, 8'h01);
		repeat (2 * SS) @(negedge clk);
		cmp(obs(3), {5'h0, need});
		cmp(obs(2), 8'h01);
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		#(20000 * 8);
		miscompares++;
		stop_test();
	end
	initial begin
		rst();
		rd(bfps_pkg::ADDR_CFG, bfps_pkg::CFG_RESET);
		rd(bfps_pkg::ADDR_STAT, bfps_pkg::STAT_RESET);
		rd(8'h55, 8'h00);
		cmp(obs(2), 8'h00);
		$display("test reset done");
		cond[3] = 1'b1; // duty-cycle dimming before any supply
		repeat (5) @(negedge clk);
		cond[2] = 1'b1;
		repeat (5) @(negedge clk);
		cond[0] = 1'b1;
		repeat (20) @(negedge clk);
		cmp(obs(2), 8'h00);
		start_up(3'h7);
		$display("test start done");
		wr(bfps_pkg::ADDR_CFG, 8'h00); // after power-up
		rd(bfps_pkg::ADDR_CFG, 8'h00);
		cmp({7'h0, overvoltage_monitor_en}, 8'h01);
		$display("test config done");
		for (int k = 0; k < 4; k++) begin
			cond[k] = 1'b0;
			poll(1, 8'h03, 8'h00, 10);
			poll(2, 8'h01, 8'h00, 10);
			rd(bfps_pkg::ADDR_CFG, 8'h00);
			start_up(3'h2);
		end
		$display("test power off done");
		rst();
		start_up(3'h7);
		sink_low = 2'b01;
		poll(4, 8'h01, 8'h01, 6);
		sink_at_max = 2'b10; // good channel reaches its headroom ceiling
		repeat (4) @(negedge clk);
		repeat (6) begin
			@(negedge clk);
			cmp(obs(4), 8'h00);
		end
		poll(0, 8'h40, 8'h40, OTO + 10);
		cmp(obs(1), 8'h02);
		cmp({7'h0, ^reg_rdata[2:1]}, 8'h01);
		$display("test open done");
		rst();
		start_up(3'h7);
		sink_short = 2'b10;
		repeat (STO / 2) @(negedge clk);
		cmp(obs(0) & 8'h40, 8'h00);
		poll(0, 8'h40, 8'h40, STO + 10);
		cmp(obs(1), 8'h02);
		$display("test short done");
		rst();
		overcur = 1'b1; // current at limit through precharge and the first three soft steps
		cond = 4'hF;
		poll(1, 8'h03, 8'h03, 30);
		repeat (3 * SS) @(negedge clk);
		cmp(obs(0) & 8'h10, 8'h00);
		overcur = 1'b0;
		repeat (5 * SS) @(negedge clk);
		cmp(obs(2), 8'h01);
		overcur = 1'b1;
		poll(5, 8'h01, 8'h01, 5);
		overcur = 1'b0;
		repeat (CTO + 5) @(negedge clk);
		cmp(obs(0) & 8'h10, 8'h00);
		overcur = 1'b1;
		poll(0, 8'h10, 8'h10, CTO + 10);
		overcur = 1'b0;
		$display("test overcurrent done");
		over_temp = 1'b1;
		poll(0, 8'h80, 8'h80, 5);
		poll(2, 8'h03, 8'h00, 5);
		cmp(obs(1), 8'h00);
		over_temp = 1'b0;
		repeat (20) @(negedge clk);
		cmp(obs(2), 8'h00);
		cond[2] = 1'b0;
		repeat (5) @(negedge clk);
		start_up(3'h7);
		$display("test thermal done");
		stop_test();
	end
endmodule
